// ==== verilog/bmpc_pkg.sv ====
// Shared constants and types for the branch and multiply/divide pipeline control
package bmpc_pkg;

  localparam int XLEN = 64;
  localparam int IMM_W = 16;
  localparam int TARGET_W = 26;
  localparam int WORD_W = 32;
  localparam int INSTR_SHIFT = 2;
  localparam int PC_KEEP_W = 4;
  localparam int ABS_LOW_W = TARGET_W + INSTR_SHIFT;
  localparam int BR_EXT_W = XLEN - IMM_W - INSTR_SHIFT;
  localparam int IMM_EXT_W = XLEN - IMM_W;
  localparam int REG_IDX_W = 5;
  localparam int CNT_W = 7;

  localparam logic [REG_IDX_W-1:0] LINK_REG = 5'h1f;
  localparam logic [XLEN-1:0] INSTR_BYTES = 64'h0000_0000_0000_0004;
  localparam logic [XLEN-1:0] RETURN_OFFSET = 64'h0000_0000_0000_0008;

  // Pipeline cycles a following high/low access must wait
  localparam logic [CNT_W-1:0] STALL_MUL32 = 7'h01;
  localparam logic [CNT_W-1:0] STALL_SHORT_MULTIPLY_ACCUMULATE = 7'h01;
  localparam logic [CNT_W-1:0] STALL_MUL64 = 7'h04;
  localparam logic [CNT_W-1:0] STALL_DIV32 = 7'h23;
  localparam logic [CNT_W-1:0] STALL_DIV64 = 7'h43;

  typedef enum logic [4:0] {
    OP_NONE,
    OP_ALU_IMM,
    OP_ALU_REG,
    OP_SHIFT,
    OP_MUL32,
    OP_MUL64,
    OP_DIV32,
    OP_DIV64,
    OP_SHORT_MULTIPLY_ACCUMULATE,
    OP_READ_HIGH,
    OP_READ_LOW,
    OP_WRITE_HILO,
    OP_JUMP_ABS,
    OP_CALL_ABS,
    OP_JUMP_REG,
    OP_CALL_REG,
    OP_BRANCH,
    OP_BRANCH_LINK,
    OP_SYSCALL,
    OP_BREAKPOINT,
    OP_TRAP,
    OP_MP_SYNC
  } bmpc_op_t;

  typedef enum logic [3:0] {
    CND_EQ,
    CND_NE,
    CND_LEZ,
    CND_GTZ,
    CND_LTZ,
    CND_GEZ,
    CND_COP_TRUE,
    CND_COP_FALSE,
    CND_GE,
    CND_GEU,
    CND_LT,
    CND_LTU
  } bmpc_cond_t;

  typedef enum logic [1:0] {
    CAT_ALU_IMM,
    CAT_REG3,
    CAT_SHIFT,
    CAT_MULDIV
  } bmpc_cat_t;

endpackage

// ==== verilog/bmpc_hilo_timer.sv ====
// Countdown that keeps the high/low result registers busy after multiply or divide
`timescale 1ns/10ps
module bmpc_hilo_timer
  import bmpc_pkg::*;
#(
  parameter int CW = CNT_W
)
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic load_i,
  input wire logic [CW-1:0] load_count_i,
  output logic busy_o,
  output logic [CW-1:0] remaining_o
);

  typedef enum logic {
    ST_IDLE,
    ST_BUSY
  } bmpc_timer_state_t;

  bmpc_timer_state_t state_q;
  bmpc_timer_state_t state_d;
  logic [CW-1:0] count_q;
  logic [CW-1:0] count_d;
  logic last_tick;

  assign last_tick = (count_q == CW'(1));
  assign count_d = load_i ? load_count_i : ((state_q == ST_BUSY) ? count_q - CW'(1) : count_q);

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: if (load_i && load_count_i != '0) state_d = ST_BUSY;
      ST_BUSY: if (!load_i && last_tick) state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      state_q <= ST_IDLE;
      count_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      count_q <= count_d;
    end
  end

  assign busy_o = (state_q == ST_BUSY);
  assign remaining_o = count_q;

endmodule

// ==== verilog/bmpc_pipe_ctrl.sv ====
// Jump, branch and multiply/divide interlock control of the five-stage pipeline
`timescale 1ns/10ps
module bmpc_pipe_ctrl
  import bmpc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic issue_valid_i,
  input wire bmpc_op_t issue_op_i,
  input wire bmpc_cond_t issue_cond_i,
  input wire logic issue_likely_i,
  input wire logic issue_word_op_i,
  input wire logic issue_imm_zext_i,
  input wire logic [XLEN-1:0] issue_pc_i,
  input wire logic [XLEN-1:0] issue_rs_val_i,
  input wire logic [XLEN-1:0] issue_rt_val_i,
  input wire logic [IMM_W-1:0] issue_imm_i,
  input wire logic [TARGET_W-1:0] issue_target_i,
  input wire logic cop_cond_i,
  output logic stall_o,
  output logic nullify_o,
  output logic redirect_o,
  output logic [XLEN-1:0] redirect_pc_o,
  output logic ex_valid_o,
  output bmpc_cat_t ex_category_o,
  output logic ex_is_compute_o,
  output logic [XLEN-1:0] ex_operand_a_o,
  output logic [XLEN-1:0] ex_operand_b_o,
  output logic ex_operand_undef_o,
  output logic sw_exception_o,
  output logic reserved_instr_o,
  output logic hilo_busy_o,
  output logic wb_link_we_o,
  output logic [REG_IDX_W-1:0] wb_link_addr_o,
  output logic [XLEN-1:0] wb_link_data_o
);

  // Decode of the instruction in the operand_read_stage
  logic is_muldiv;
  logic is_hilo_user;
  logic is_branch;
  logic is_jump;
  logic is_link;
  logic is_compute;
  logic accept;
  logic hilo_busy;
  logic [CNT_W-1:0] hilo_remaining;
  logic [CNT_W-1:0] muldiv_count;
  logic signed [XLEN-1:0] rs_s;
  logic signed [XLEN-1:0] rt_s;
  logic cond_true;
  logic transfer_taken;
  logic likely_kill;
  logic rs_bad_ext;
  logic rt_bad_ext;
  logic uses_rt;
  logic operand_undef;
  logic [XLEN-1:0] delay_pc;
  logic [XLEN-1:0] branch_offset;
  logic [XLEN-1:0] abs_target;
  logic [XLEN-1:0] transfer_target;
  logic [XLEN-1:0] imm_ext;
  logic [XLEN-1:0] operand_b;
  logic trap_hit;
  bmpc_cat_t category;

  // Compute_stage, data-cache and write-back stage registers
  logic ex_valid_q;
  logic dc_valid_q;
  logic wb_valid_q;
  logic redirect_q;
  logic nullify_q;
  logic [XLEN-1:0] redirect_pc_q;
  bmpc_cat_t ex_category_q;
  logic ex_is_compute_q;
  logic [XLEN-1:0] ex_operand_a_q;
  logic [XLEN-1:0] ex_operand_b_q;
  logic ex_operand_undef_q;
  logic sw_exception_q;
  logic reserved_instr_q;
  logic ex_link_q;
  logic dc_link_q;
  logic wb_link_q;
  logic [XLEN-1:0] ex_ret_q;
  logic [XLEN-1:0] dc_ret_q;
  logic [XLEN-1:0] wb_ret_q;

  assign is_muldiv = (issue_op_i == OP_MUL32) || (issue_op_i == OP_MUL64) ||
                     (issue_op_i == OP_DIV32) || (issue_op_i == OP_DIV64) ||
                     (issue_op_i == OP_SHORT_MULTIPLY_ACCUMULATE);
  assign is_hilo_user = is_muldiv || (issue_op_i == OP_READ_HIGH) ||
                        (issue_op_i == OP_READ_LOW) || (issue_op_i == OP_WRITE_HILO);
  assign is_branch = (issue_op_i == OP_BRANCH) || (issue_op_i == OP_BRANCH_LINK);
  assign is_jump = (issue_op_i == OP_JUMP_ABS) || (issue_op_i == OP_CALL_ABS) ||
                   (issue_op_i == OP_JUMP_REG) || (issue_op_i == OP_CALL_REG);
  assign is_link = (issue_op_i == OP_CALL_ABS) || (issue_op_i == OP_CALL_REG) ||
                   (issue_op_i == OP_BRANCH_LINK);
  assign is_compute = (issue_op_i == OP_ALU_IMM) || (issue_op_i == OP_ALU_REG) ||
                      (issue_op_i == OP_SHIFT) || is_muldiv;

  // High/low users wait; everything else flows on
  assign stall_o = issue_valid_i && is_hilo_user && hilo_busy && !nullify_o;
  assign accept = issue_valid_i && !stall_o && !nullify_o;

  assign muldiv_count = (issue_op_i == OP_MUL64) ? STALL_MUL64 :
                        (issue_op_i == OP_DIV32) ? STALL_DIV32 :
                        (issue_op_i == OP_DIV64) ? STALL_DIV64 :
                        (issue_op_i == OP_SHORT_MULTIPLY_ACCUMULATE) ? STALL_SHORT_MULTIPLY_ACCUMULATE : STALL_MUL32;

  bmpc_hilo_timer #(
    .CW(CNT_W)
  ) u_hilo_timer (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .load_i(accept && is_muldiv),
    .load_count_i(muldiv_count),
    .busy_o(hilo_busy),
    .remaining_o(hilo_remaining)
  );

  // Branch and trap comparison, done before the compute_stage edge
  assign rs_s = issue_rs_val_i;
  assign rt_s = issue_rt_val_i;
  assign cond_true = (issue_cond_i == CND_EQ) ? (issue_rs_val_i == issue_rt_val_i) :
                     (issue_cond_i == CND_NE) ? (issue_rs_val_i != issue_rt_val_i) :
                     (issue_cond_i == CND_LEZ) ? (rs_s <= 0) :
                     (issue_cond_i == CND_GTZ) ? (rs_s > 0) :
                     (issue_cond_i == CND_LTZ) ? (rs_s < 0) :
                     (issue_cond_i == CND_GEZ) ? (rs_s >= 0) :
                     (issue_cond_i == CND_COP_TRUE) ? cop_cond_i :
                     (issue_cond_i == CND_COP_FALSE) ? !cop_cond_i :
                     (issue_cond_i == CND_GE) ? (rs_s >= rt_s) :
                     (issue_cond_i == CND_GEU) ? (issue_rs_val_i >= issue_rt_val_i) :
                     (issue_cond_i == CND_LT) ? (rs_s < rt_s) :
                     (issue_rs_val_i < issue_rt_val_i);

  assign delay_pc = issue_pc_i + INSTR_BYTES;
  assign branch_offset = {{BR_EXT_W{issue_imm_i[IMM_W-1]}}, issue_imm_i,
                          {INSTR_SHIFT{1'b0}}};
  assign abs_target = {issue_pc_i[XLEN-1:XLEN-PC_KEEP_W], {(XLEN-PC_KEEP_W-ABS_LOW_W){1'b0}},
                       issue_target_i, {INSTR_SHIFT{1'b0}}};
  assign transfer_target = is_branch ? delay_pc + branch_offset :
                           ((issue_op_i == OP_JUMP_REG) || (issue_op_i == OP_CALL_REG)) ?
                           issue_rs_val_i : abs_target;
  assign transfer_taken = is_jump || (is_branch && cond_true);
  assign likely_kill = is_branch && issue_likely_i && !cond_true;
  assign trap_hit = (issue_op_i == OP_SYSCALL) || (issue_op_i == OP_BREAKPOINT) ||
                    ((issue_op_i == OP_TRAP) && cond_true);

  // Operand formats and sign-extension check
  assign imm_ext = issue_imm_zext_i ? {{IMM_EXT_W{1'b0}}, issue_imm_i} :
                   {{IMM_EXT_W{issue_imm_i[IMM_W-1]}}, issue_imm_i};
  assign operand_b = (issue_op_i == OP_ALU_IMM) ? imm_ext : issue_rt_val_i;
  assign uses_rt = (issue_op_i != OP_ALU_IMM);
  assign rs_bad_ext = issue_rs_val_i[XLEN-1:WORD_W] != {(XLEN-WORD_W){issue_rs_val_i[WORD_W-1]}};
  assign rt_bad_ext = issue_rt_val_i[XLEN-1:WORD_W] != {(XLEN-WORD_W){issue_rt_val_i[WORD_W-1]}};
  assign operand_undef = is_compute && issue_word_op_i &&
                         (rs_bad_ext || (uses_rt && rt_bad_ext));
  assign category = (issue_op_i == OP_ALU_IMM) ? CAT_ALU_IMM :
                    (issue_op_i == OP_ALU_REG) ? CAT_REG3 :
                    (issue_op_i == OP_SHIFT) ? CAT_SHIFT : CAT_MULDIV;

  // Compute, data-cache and write-back stages advance once per pipeline_cycle
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      ex_valid_q <= 1'b0;
      dc_valid_q <= 1'b0;
      wb_valid_q <= 1'b0;
    end
    else
    begin
      ex_valid_q <= accept;
      dc_valid_q <= ex_valid_q;
      wb_valid_q <= dc_valid_q;
    end
  end

  // Redirect reaches fetch in compute_stage; delay slot keeps going unless an untaken likely branch nullifies it
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      redirect_q <= 1'b0;
      nullify_q <= 1'b0;
      redirect_pc_q <= '0;
    end
    else
    begin
      redirect_q <= accept && transfer_taken;
      nullify_q <= accept && likely_kill;
      redirect_pc_q <= accept ? transfer_target : redirect_pc_q;
    end
  end

  // Compute_stage operand and event registers
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      ex_category_q <= CAT_ALU_IMM;
      ex_is_compute_q <= 1'b0;
      ex_operand_a_q <= '0;
      ex_operand_b_q <= '0;
      ex_operand_undef_q <= 1'b0;
      sw_exception_q <= 1'b0;
      reserved_instr_q <= 1'b0;
    end
    else
    begin
      ex_category_q <= accept ? category : ex_category_q;
      ex_is_compute_q <= accept && is_compute;
      ex_operand_a_q <= accept ? issue_rs_val_i : ex_operand_a_q;
      ex_operand_b_q <= accept ? operand_b : ex_operand_b_q;
      ex_operand_undef_q <= accept && operand_undef;
      sw_exception_q <= accept && trap_hit;
      reserved_instr_q <= accept && (issue_op_i == OP_MP_SYNC);
    end
  end

  // Return address travels to write-back
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      ex_link_q <= 1'b0;
      dc_link_q <= 1'b0;
      wb_link_q <= 1'b0;
      ex_ret_q <= '0;
      dc_ret_q <= '0;
      wb_ret_q <= '0;
    end
    else
    begin
      ex_link_q <= accept && is_link;
      dc_link_q <= ex_link_q;
      wb_link_q <= dc_link_q;
      ex_ret_q <= accept ? issue_pc_i + RETURN_OFFSET : ex_ret_q;
      dc_ret_q <= ex_ret_q;
      wb_ret_q <= dc_ret_q;
    end
  end

  assign nullify_o = nullify_q;
  assign redirect_o = redirect_q;
  assign redirect_pc_o = redirect_pc_q;
  assign ex_valid_o = ex_valid_q;
  assign ex_category_o = ex_category_q;
  assign ex_is_compute_o = ex_is_compute_q;
  assign ex_operand_a_o = ex_operand_a_q;
  assign ex_operand_b_o = ex_operand_b_q;
  assign ex_operand_undef_o = ex_operand_undef_q;
  assign sw_exception_o = sw_exception_q;
  assign reserved_instr_o = reserved_instr_q;
  assign hilo_busy_o = hilo_busy;
  assign wb_link_we_o = wb_link_q && wb_valid_q;
  assign wb_link_addr_o = LINK_REG;
  assign wb_link_data_o = wb_ret_q;

  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_take_div64;
    accept && issue_op_i == OP_DIV64;
  endsequence

  sequence s_take_mul64;
    accept && issue_op_i == OP_MUL64;
  endsequence

  a_mul64_window: assert property (s_take_mul64 |=> hilo_busy[*4] ##1 !hilo_busy)
    else $error("wide multiply busy window is not four cycles");
  a_mul32_window: assert property (accept && issue_op_i == OP_MUL32 |=>
    hilo_busy ##1 !hilo_busy)
    else $error("short multiply busy window is not one cycle");
  a_div32_window: assert property (accept && issue_op_i == OP_DIV32 |->
    ##35 hilo_busy ##1 !hilo_busy)
    else $error("divide busy window is not 35 cycles");
  a_div64_window: assert property (s_take_div64 |-> ##67 hilo_busy ##1 !hilo_busy)
    else $error("wide divide busy window is not 67 cycles");
  a_read_stalls: assert property (issue_valid_i && (issue_op_i == OP_READ_LOW) &&
    hilo_busy && !nullify_o |-> stall_o)
    else $error("result read passed a running multiply or divide");
  a_busy_count: assert property (hilo_busy == (hilo_remaining != '0))
    else $error("busy state and remaining count disagree");
  a_others_flow: assert property (issue_valid_i && !is_hilo_user |-> !stall_o)
    else $error("independent instruction stalled");
  a_branch_target: assert property (accept && is_branch && cond_true |=>
    redirect_o && redirect_pc_o == $past(issue_pc_i) + INSTR_BYTES + $past(branch_offset))
    else $error("branch target wrong or late");
  a_reg_target: assert property (accept && issue_op_i == OP_JUMP_REG |=>
    redirect_o && redirect_pc_o == $past(issue_rs_val_i))
    else $error("register jump target wrong");
  a_abs_target: assert property (accept && issue_op_i == OP_JUMP_ABS |=>
    redirect_pc_o[ABS_LOW_W-1:0] == {$past(issue_target_i), {INSTR_SHIFT{1'b0}}})
    else $error("absolute jump target wrong");
  a_likely_nullify: assert property (accept && likely_kill |=> nullify_o && !redirect_o
    ##1 !nullify_o)
    else $error("untaken likely branch did not nullify its slot once");
  a_plain_no_null: assert property (accept && is_branch && !issue_likely_i |=> !nullify_o)
    else $error("ordinary branch nullified its slot");
  a_link_write: assert property (accept && is_link |-> ##3 wb_link_we_o &&
    wb_link_addr_o == LINK_REG && wb_link_data_o == $past(issue_pc_i, 3) + RETURN_OFFSET)
    else $error("link write wrong");
  a_trap_raise: assert property (accept && issue_op_i == OP_SYSCALL |=> sw_exception_o)
    else $error("system call raised no exception");
  a_mp_reserved: assert property (accept && issue_op_i == OP_MP_SYNC |=>
    reserved_instr_o && !ex_is_compute_o)
    else $error("synchronisation instruction not refused");
  a_undef_flag: assert property (accept && is_compute && issue_word_op_i && rs_bad_ext |=>
    ex_operand_undef_o)
    else $error("bad sign-extension not flagged");
  a_imm_operand: assert property (accept && issue_op_i == OP_ALU_IMM |=>
    ex_operand_b_o[IMM_W-1:0] == $past(issue_imm_i) && ex_category_o == CAT_ALU_IMM)
    else $error("immediate operand wrong");

endmodule

// ==== tb/test_branch_muldiv_pipeline_ctrl.sv ====
// Self-checking bench for the branch and multiply/divide pipeline control
`timescale 1ns/10ps
module test_branch_muldiv_pipeline_ctrl;
  import bmpc_pkg::*;
  logic clk_i, rst_n_i, issue_valid_i, issue_likely_i, issue_word_op_i, issue_imm_zext_i;
  logic cop_cond_i, stall_o, nullify_o, redirect_o, ex_valid_o, ex_is_compute_o;
  logic ex_operand_undef_o, sw_exception_o, reserved_instr_o, hilo_busy_o, wb_link_we_o;
  bmpc_op_t issue_op_i;
  bmpc_cond_t issue_cond_i;
  bmpc_cat_t ex_category_o;
  logic [XLEN-1:0] issue_pc_i, issue_rs_val_i, issue_rt_val_i, redirect_pc_o;
  logic [XLEN-1:0] ex_operand_a_o, ex_operand_b_o, wb_link_data_o, exp_v;
  logic [IMM_W-1:0] issue_imm_i;
  logic [TARGET_W-1:0] issue_target_i;
  logic [REG_IDX_W-1:0] wb_link_addr_o;
  logic tk, lk, ex;
  integer seed;
  int n_mismatch = 0;
  int n_checks = 0;
  int n;
  bmpc_op_t md_ops [5] = '{OP_MUL32, OP_SHORT_MULTIPLY_ACCUMULATE, OP_MUL64, OP_DIV32, OP_DIV64};
  int md_wait [5] = '{1, 1, 4, 35, 67};
  bmpc_op_t rd_ops [5] = '{OP_READ_HIGH, OP_READ_LOW, OP_WRITE_HILO, OP_READ_LOW, OP_READ_HIGH};
  bmpc_op_t jp_ops [5] = '{OP_JUMP_ABS, OP_CALL_ABS, OP_JUMP_REG, OP_CALL_REG, OP_BRANCH_LINK};
  bmpc_op_t ev_ops [4] = '{OP_SYSCALL, OP_BREAKPOINT, OP_TRAP, OP_MP_SYNC};
  bmpc_cond_t tr_cnd [6] = '{CND_EQ, CND_NE, CND_GE, CND_GEU, CND_LT, CND_LTU};
  bmpc_op_t cp_ops [3] = '{OP_ALU_IMM, OP_ALU_REG, OP_SHIFT};
  bmpc_cat_t cp_cat [3] = '{CAT_ALU_IMM, CAT_REG3, CAT_SHIFT};

  bmpc_pipe_ctrl dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .issue_valid_i(issue_valid_i), .issue_op_i(issue_op_i),
    .issue_cond_i(issue_cond_i), .issue_likely_i(issue_likely_i),
    .issue_word_op_i(issue_word_op_i), .issue_imm_zext_i(issue_imm_zext_i),
    .issue_pc_i(issue_pc_i), .issue_rs_val_i(issue_rs_val_i), .issue_rt_val_i(issue_rt_val_i),
    .issue_imm_i(issue_imm_i), .issue_target_i(issue_target_i), .cop_cond_i(cop_cond_i),
    .stall_o(stall_o), .nullify_o(nullify_o), .redirect_o(redirect_o),
    .redirect_pc_o(redirect_pc_o), .ex_valid_o(ex_valid_o), .ex_category_o(ex_category_o),
    .ex_is_compute_o(ex_is_compute_o), .ex_operand_a_o(ex_operand_a_o),
    .ex_operand_b_o(ex_operand_b_o), .ex_operand_undef_o(ex_operand_undef_o),
    .sw_exception_o(sw_exception_o), .reserved_instr_o(reserved_instr_o),
    .hilo_busy_o(hilo_busy_o), .wb_link_we_o(wb_link_we_o), .wb_link_addr_o(wb_link_addr_o),
    .wb_link_data_o(wb_link_data_o)
  );

  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  task automatic chk_val(input logic [63:0] got, input logic [63:0] expv);
    n_checks++;
    if (got !== expv)
    begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, expv);
    end
  endtask

  task automatic chk_flag(input logic got, input logic expv);
    n_checks++;
    if (got !== expv)
    begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, expv);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Presents the set-up instruction across one edge; valid stays up for the next one
  task automatic go;
    issue_valid_i = 1'b1;
    @(negedge clk_i);
  endtask

  task automatic rnd_fields;
    issue_pc_i = {$random(seed), $random(seed) & 32'hffff_fffc};
    issue_rs_val_i = {$random(seed), $random(seed)};
    issue_rt_val_i = {$random(seed), $random(seed)};
    issue_imm_i = 16'($random(seed));
    issue_target_i = 26'($random(seed));
    cop_cond_i = 1'($random(seed));
    issue_word_op_i = 1'b0;
    issue_likely_i = 1'b0;
  endtask

  function automatic logic taken(input bmpc_cond_t c, input logic [63:0] a, input logic [63:0] b,
                                 input logic cp);
    case (c)
      CND_EQ: return a == b;
      CND_NE: return a != b;
      CND_LEZ: return $signed(a) <= 0;
      CND_GTZ: return $signed(a) > 0;
      CND_LTZ: return a[63];
      CND_GEZ: return !a[63];
      CND_COP_TRUE: return cp;
      CND_COP_FALSE: return !cp;
      CND_GE: return $signed(a) >= $signed(b);
      CND_GEU: return a >= b;
      CND_LT: return $signed(a) < $signed(b);
      default: return a < b;
    endcase
  endfunction

  function automatic logic [63:0] br_target(input logic [63:0] pc, input logic [15:0] imm);
    return pc + 64'h4 + {{46{imm[15]}}, imm, 2'b00};
  endfunction

  function automatic logic bad_ext(input logic [63:0] v);
    return v[63:32] != {32{v[31]}};
  endfunction

  initial
  begin
    #(40 * 5000);
    n_mismatch++;
    give_verdict();
  end

  initial
  begin
    seed = 32'h93f1779b;
    rst_n_i = 1'b0;
    issue_valid_i = 1'b0;
    issue_op_i = OP_NONE;
    issue_cond_i = CND_EQ;
    issue_imm_zext_i = 1'b0;
    rnd_fields();
    repeat (10) @(negedge clk_i);
    rst_n_i = 1'b1;
    chk_flag(stall_o, 1'b0);
    chk_flag(redirect_o, 1'b0);
    chk_val(64'(wb_link_addr_o), 64'h1f);
    // Multiply/divide busy spans, with an independent op slipped in
    for (int i = 0; i < 5; i++)
    begin
      rnd_fields();
      issue_op_i = md_ops[i];
      go();
      chk_flag(hilo_busy_o, 1'b1);
      chk_val(64'(ex_category_o), 64'(CAT_MULDIV));
      issue_op_i = OP_ALU_REG;
      #1;
      chk_flag(stall_o, 1'b0);
      go();
      chk_flag(ex_valid_o, 1'b1);
      issue_op_i = rd_ops[i];
      issue_valid_i = 1'b1;
      n = 0;
      #1;
      while (stall_o === 1'b1 && n < 100)
      begin
        @(negedge clk_i);
        #1;
        n++;
      end
      chk_val(64'(n), 64'(md_wait[i] - 1));
      @(negedge clk_i);
      chk_flag(ex_valid_o, 1'b1);
    end
    // Conditional branches, plain and likely, with their delay slots
    for (int i = 0; i < 48; i++)
    begin
      rnd_fields();
      if (i % 3 == 0)
        issue_rt_val_i = issue_rs_val_i;
      if (i % 5 == 0)
        issue_rs_val_i = 64'h0;
      issue_op_i = OP_BRANCH;
      issue_cond_i = bmpc_cond_t'(i % 8);
      issue_likely_i = 1'((i / 8) % 2);
      lk = issue_likely_i;
      tk = taken(issue_cond_i, issue_rs_val_i, issue_rt_val_i, cop_cond_i);
      go();
      chk_flag(redirect_o, tk);
      if (tk)
        chk_val(redirect_pc_o, br_target(issue_pc_i, issue_imm_i));
      chk_flag(nullify_o, lk && !tk);
      issue_op_i = OP_ALU_REG;
      go();
      chk_flag(ex_valid_o, !(lk && !tk));
    end
    // Jumps and linking transfers
    for (int i = 0; i < 10; i++)
    begin
      rnd_fields();
      issue_op_i = jp_ops[i % 5];
      issue_cond_i = CND_LTZ;
      issue_rs_val_i[63] = 1'b1;
      go();
      chk_flag(redirect_o, 1'b1);
      if (issue_op_i inside {OP_JUMP_ABS, OP_CALL_ABS})
        chk_val({redirect_pc_o[63:60], 32'h0, redirect_pc_o[27:0]},
                {issue_pc_i[63:60], 32'h0, issue_target_i, 2'b00});
      else if (issue_op_i inside {OP_JUMP_REG, OP_CALL_REG})
        chk_val(redirect_pc_o, issue_rs_val_i);
      else
        chk_val(redirect_pc_o, br_target(issue_pc_i, issue_imm_i));
      issue_op_i = OP_ALU_IMM;
      go();
      chk_flag(ex_valid_o, 1'b1);
      @(negedge clk_i);
      lk = (i % 5) inside {1, 3, 4};
      chk_flag(wb_link_we_o, lk);
      if (lk)
      begin
        chk_val(64'(wb_link_addr_o), 64'h1f);
        chk_val(wb_link_data_o, issue_pc_i + 64'h8);
      end
    end
    // Software exceptions and unsupported synchronisation
    for (int i = 0; i < 24; i++)
    begin
      rnd_fields();
      if ((i / 4) % 2 == 0)
        issue_rt_val_i = issue_rs_val_i;
      issue_op_i = ev_ops[i % 4];
      issue_cond_i = tr_cnd[(i / 4) % 6];
      ex = (i % 4 < 2) || (i % 4 == 2 &&
           taken(issue_cond_i, issue_rs_val_i, issue_rt_val_i, cop_cond_i));
      go();
      chk_flag(sw_exception_o, ex);
      chk_flag(reserved_instr_o, i % 4 == 3);
    end
    // Computational operand formats and categories
    for (int i = 0; i < 30; i++)
    begin
      rnd_fields();
      issue_op_i = cp_ops[i % 3];
      issue_word_op_i = 1'($random(seed));
      issue_imm_zext_i = 1'($random(seed));
      if ($random(seed) & 1)
        issue_rs_val_i = {{32{issue_rs_val_i[31]}}, issue_rs_val_i[31:0]};
      if ($random(seed) & 1)
        issue_rt_val_i = {{32{issue_rt_val_i[31]}}, issue_rt_val_i[31:0]};
      exp_v = issue_imm_zext_i ? {48'h0, issue_imm_i} : {{48{issue_imm_i[15]}}, issue_imm_i};
      if (i % 3 != 0)
        exp_v = issue_rt_val_i;
      ex = issue_word_op_i && (bad_ext(issue_rs_val_i) || (i % 3 != 0 && bad_ext(issue_rt_val_i)));
      go();
      chk_val(64'(ex_category_o), 64'(cp_cat[i % 3]));
      chk_flag(ex_is_compute_o, 1'b1);
      if (i % 3 != 2)
      begin
        chk_val(ex_operand_a_o, issue_rs_val_i);
        chk_val(ex_operand_b_o, exp_v);
      end
      chk_flag(ex_operand_undef_o, ex);
    end
    give_verdict();
  end
endmodule
